// File: include/rst_wake_params.svh
`ifndef RST_WAKE_PARAMS_SVH
`define RST_WAKE_PARAMS_SVH
// ==========================================================
// Register map
`define OFS_CAUSE 12'h000
`define OFS_CTRL 12'h004
`define OFS_VECTOR 12'h008
`define OFS_WDOG 12'h00c
// ==========================================================
// Reset-cause field positions
`define CAUSE_POR 7
`define CAUSE_PIN 6
`define CAUSE_WDOG 5
`define CAUSE_BADOP 4
`define CAUSE_BADADR 3
`define CAUSE_LOWV 1
`define CAUSE_POR_VALUE 8'h80
// Control field positions
`define CTRL_SHORT_STOP_RECOVERY_BIT 0
`define CTRL_STOPEN 1
`define CTRL_EMUL 2
`define CTRL_WDOG_EN 3
`define CTRL_RESET 4'h1
// ==========================================================
// Timing in oscillator cycles
`define STAB_CYCLES 4096
`define SHORT_CYCLES 32
`define PIN_CYCLES 32
`define HOLD_CYCLES 32
`define SAMPLE_CYCLES 32
`define WDOG_CYCLES 65536
// ==========================================================
// Vectors
`define VEC_RESET 16'hfffe
`define VEC_SWI 16'hfffc
`define VEC_IRQ 16'hfffa
`define VEC_CLKGEN 16'hfff8
`define VEC_T1C0 16'hfff6
`define VEC_T1C1 16'hfff4
`define VEC_T1OV 16'hfff2
`define VEC_T2C0 16'hfff0
`define VEC_T2C1 16'hffee
`define VEC_T2OV 16'hffec
`define VEC_SPIRX 16'hffea
`define VEC_SPITX 16'hffe8
`define VEC_SCIERR 16'hffe6
`define VEC_SCIRX 16'hffe4
`define VEC_SCITX 16'hffe2
`define VEC_KEYPAD 16'hffe0
`define VEC_ADC 16'hffde
`define VEC_TBASE 16'hffdc
`define VEC_CANWAKE 16'hffda
`define VEC_CANERR 16'hffd8
`define VEC_CANRX 16'hffd6
`define VEC_CANTX 16'hffd4
`endif

// File: include/rst_wake_pkg.sv
package rst_wake_pkg;
  typedef enum {st_power, st_pin_low, st_hold, st_run, st_wait, st_stop, st_recover}
    seq_state_type;
endpackage : rst_wake_pkg

// File: design/reset_wake_sequencer.sv
// Function
// RULE1 - Timers run in wait; enabled timer request ends wait.
// RULE2 - Timers halt in stop, keep state, resume after external interrupt.
// RULE3 - Wait exit restarts CPU clock; reset pin, watchdog, low voltage fetch FFFE.
// RULE4 - Falling interrupt-pin edge wakes wait or stop, vector FFFA.
// RULE5 - Break ends wait only in emulation mode, vector FFFC.
// RULE6 - Timer vectors FFF2/FFF4/FFF6 and FFEC/FFEE/FFF0.
// RULE7 - Serial vectors FFE8, FFEA, FFE2, FFE4, FFE6.
// RULE8 - Clock gen FFF8, keypad FFE0, ADC FFDE, timebase FFDC, CAN FFD4-FFDA.
// RULE9 - Only listed events end stop; keypad vectors FFE0.
// RULE10 - Timebase rollover in stop wakes via FFDC.
// RULE11 - CAN wakes from stop but ignores data until clocks run.
// RULE12 - Stop recovery holds clocks off 4096 cycles, 12-bit counter.
// RULE13 - Short recovery bit cuts delay to 32 cycles.
// RULE14 - Software keeps short recovery clear with external crystal.
// RULE15 - Reset aborts, initialises bits, fetches FFFE, bus clock osc/4.
// RULE16 - Reset pin low causes reset and sets external flag.
// RULE17 - Internal reset drives pin 32 cycles, then holds 32 more.
// RULE18 - Power-on: 4096 stabilise, pin +32, CPU +64, set POR and low-voltage.
// RULE19 - Low voltage: pin low while low, then 4096, +32, +64, set flag.
// RULE20 - Watchdog overflow resets, sets flag; any write clears counter.
// RULE21 - Bad opcode or disabled stop resets, sets bad-opcode flag.
// RULE22 - Opcode fetch unmapped resets, sets bad-address; data fetch does not.
// RULE23 - Cause register clears on read; after power-on POR and low-voltage set.
// RULE24 - Pin sampled 32 cycles after release; still low sets external flag.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "rst_wake_params.svh"
module reset_wake_sequencer #(
  parameter int STAB_CYCLES = `STAB_CYCLES,
  parameter int WDOG_CYCLES = `WDOG_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe_out,
  input wire logic supply_low_in,
  input wire logic bad_opcode_in,
  input wire logic stop_instr_in,
  input wire logic wait_instr_in,
  input wire logic opcode_fetch_in,
  input wire logic unmapped_in,
  input wire logic irq_pin_in,
  input wire logic keypad_fall_in,
  input wire logic break_in,
  input wire logic [17:0] wake_req_in,
  output logic cpu_reset_out,
  output logic cpu_clk_en_out,
  output logic sys_clk_en_out,
  output logic timer_run_out,
  output logic can_rx_en_out,
  output logic bus_div4_out,
  output logic vector_load_out,
  output logic [15:0] vector_out
);
  // ==========================================================
  // Vector table for wake_req_in bits, highest priority first
  localparam logic [15:0] WAKE_VEC [18] = '{`VEC_CLKGEN, `VEC_T1C0, `VEC_T1C1, `VEC_T1OV,
    `VEC_T2C0, `VEC_T2C1, `VEC_T2OV, `VEC_SPIRX, `VEC_SPITX, `VEC_SCIERR, `VEC_SCIRX,
    `VEC_SCITX, `VEC_KEYPAD, `VEC_ADC, `VEC_TBASE, `VEC_CANWAKE, `VEC_CANERR, `VEC_CANRX};
  localparam int CAN_TX = 18;
  localparam logic [16:0] STAB_M1 = 17'(STAB_CYCLES - 1);
  localparam logic [16:0] SHORT_M1 = 17'(`SHORT_CYCLES - 1);
  localparam logic [16:0] PIN_M1 = 17'(`PIN_CYCLES - 1);
  localparam logic [16:0] HOLD_M1 = 17'(`HOLD_CYCLES - 1);
  localparam logic [16:0] SAMPLE_M1 = 17'(`SAMPLE_CYCLES - 1);
  localparam logic [16:0] WDOG_M1 = 17'(WDOG_CYCLES - 1);

  rst_wake_pkg::seq_state_type state, next_state;
  logic [16:0] count, next_count;
  logic [7:0] cause, next_cause;
  logic [3:0] ctrl, next_ctrl;
  logic [16:0] wdog, next_wdog;
  logic [5:0] sample_cnt, next_sample_cnt;
  logic irq_prev, next_irq_prev;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic next_pin_oe, next_cpu_reset, next_cpu_clk, next_sys_clk, next_timer_run;
  logic next_can_rx, next_vec_load;
  logic [15:0] next_vector;
  logic irq_fall, ext_reset, int_reset, apb_access;
  logic [15:0] wake_vec;
  logic wake_any, stop_wake;

  // ==========================================================
  // Wake source decode
  always_comb begin
    irq_fall = irq_prev & ~irq_pin_in;
    ext_reset = ~reset_pin_in & ~reset_pin_oe_out; // RULE16
    int_reset = (wdog == WDOG_M1 && ctrl[`CTRL_WDOG_EN]) // RULE20
      | bad_opcode_in | (stop_instr_in & ~ctrl[`CTRL_STOPEN]) // RULE21
      | (opcode_fetch_in & unmapped_in); // RULE22
    apb_access = psel_in & penable_in & pready_out;
    wake_any = 1'b0;
    wake_vec = `VEC_CANTX; // RULE8
    for (int i = CAN_TX - 1; i >= 0; i--) begin
      if (wake_req_in[i]) begin
        wake_any = 1'b1;
        wake_vec = WAKE_VEC[i]; // RULE6 RULE7 RULE8
      end
    end
    // Only pin, keypad, timebase and CAN activity end stop
    stop_wake = irq_fall | keypad_fall_in | wake_req_in[14] | wake_req_in[15]; // RULE9 RULE10
  end

  // ==========================================================
  // Sequencer and register next state
  always_comb begin
    next_state = state;
    next_count = count;
    next_cause = cause;
    next_ctrl = ctrl;
    next_wdog = wdog + 17'h00001;
    next_sample_cnt = sample_cnt;
    next_irq_prev = irq_pin_in;
    next_pin_oe = reset_pin_oe_out;
    next_cpu_reset = cpu_reset_out;
    next_cpu_clk = cpu_clk_en_out;
    next_sys_clk = sys_clk_en_out;
    next_timer_run = timer_run_out;
    next_can_rx = can_rx_en_out;
    next_vec_load = 1'b0;
    next_vector = vector_out;
    next_prdata = 32'h0;
    next_pready = psel_in & ~pready_out;
    next_pslverr = 1'b0;
    // Pin sampled late to catch an outside reset overlapping ours
    if (sample_cnt != 6'h00) begin
      next_sample_cnt = sample_cnt - 6'h01;
    end
    case (state)
      rst_wake_pkg::st_power: begin
        next_pin_oe = 1'b1;
        next_sys_clk = 1'b0;
        if (supply_low_in) begin
          next_count = 17'h0; // RULE19
        end else if (count == STAB_M1) begin
          next_count = 17'h0;
          next_state = rst_wake_pkg::st_pin_low;
        end else begin
          next_count = count + 17'h00001; // RULE18
        end
      end
      rst_wake_pkg::st_pin_low: begin
        next_sys_clk = 1'b1;
        next_count = count + 17'h00001;
        if (count == PIN_M1) begin
          next_pin_oe = 1'b0; // RULE17
          next_count = 17'h0;
          next_sample_cnt = 6'(`SAMPLE_CYCLES);
          next_state = rst_wake_pkg::st_hold;
        end
      end
      rst_wake_pkg::st_hold: begin
        next_count = count + 17'h00001;
        if (count == HOLD_M1) begin
          next_cpu_reset = 1'b0; // RULE17
          // Clocks back on, also after a pin reset taken while stopped
          next_sys_clk = 1'b1;
          next_cpu_clk = 1'b1;
          next_timer_run = 1'b1;
          next_can_rx = 1'b1;
          next_vec_load = 1'b1;
          next_vector = `VEC_RESET; // RULE15
          next_state = rst_wake_pkg::st_run;
        end
      end
      rst_wake_pkg::st_run: begin
        if (stop_instr_in && ctrl[`CTRL_STOPEN]) begin
          next_cpu_clk = 1'b0;
          next_sys_clk = 1'b0;
          next_timer_run = 1'b0; // RULE2
          next_can_rx = 1'b0;
          next_state = rst_wake_pkg::st_stop;
        end else if (wait_instr_in) begin
          next_cpu_clk = 1'b0; // RULE1
          next_state = rst_wake_pkg::st_wait;
        end
      end
      rst_wake_pkg::st_wait: begin
        if (irq_fall) begin
          next_vector = `VEC_IRQ; // RULE4
        end else if (break_in && ctrl[`CTRL_EMUL]) begin
          next_vector = `VEC_SWI; // RULE5
        end else begin
          next_vector = wake_vec; // RULE1
        end
        if (irq_fall || (break_in && ctrl[`CTRL_EMUL]) || wake_any) begin
          next_cpu_clk = 1'b1; // RULE3
          next_vec_load = 1'b1;
          next_state = rst_wake_pkg::st_run;
        end
      end
      rst_wake_pkg::st_stop: begin
        if (stop_wake) begin
          next_vector = irq_fall ? `VEC_IRQ : keypad_fall_in ? `VEC_KEYPAD // RULE9
            : wake_req_in[14] ? `VEC_TBASE : `VEC_CANWAKE; // RULE10
          next_count = 17'h0;
          next_state = rst_wake_pkg::st_recover;
        end
      end
      rst_wake_pkg::st_recover: begin
        next_count = count + 17'h00001; // RULE12
        if (count == (ctrl[`CTRL_SHORT_STOP_RECOVERY_BIT] ? SHORT_M1 : STAB_M1)) begin // RULE13
          next_sys_clk = 1'b1;
          next_cpu_clk = 1'b1;
          next_timer_run = 1'b1; // RULE2
          next_can_rx = 1'b1; // RULE11
          next_vec_load = 1'b1;
          next_state = rst_wake_pkg::st_run;
        end
      end
      default: next_state = rst_wake_pkg::st_power;
    endcase
    // Register access: reads of cause clear it, writes to watchdog kick it
    if (psel_in && !pready_out) begin
      case (paddr_in)
        `OFS_CAUSE: begin
          next_prdata = {24'h0, cause};
          if (!pwrite_in) begin
            next_cause = 8'h00; // RULE23
          end
        end
        `OFS_CTRL: next_prdata = {28'h0, ctrl};
        `OFS_VECTOR: next_prdata = {16'h0, vector_out};
        `OFS_WDOG: next_prdata = 32'h0;
        default: next_pslverr = 1'b1;
      endcase
    end
    if (apb_access && pwrite_in && paddr_in == `OFS_CTRL) begin
      next_ctrl = pwdata_in[3:0];
    end
    if (apb_access && pwrite_in && paddr_in == `OFS_WDOG) begin
      next_wdog = 17'h0; // RULE20
    end
    // Late pin sample sits after the read clear so that the set wins
    if (sample_cnt == 6'h01 && !reset_pin_in) begin
      next_cause[`CAUSE_PIN] = 1'b1; // RULE24
    end
    // Any reset outranks all sequencer state except next_vec_load, next_vector, next_sys_clk and next_sample_cnt; flags set here win over a read clear
    if (supply_low_in || int_reset || ext_reset) begin
      next_state = (supply_low_in) ? rst_wake_pkg::st_power
        : ext_reset ? rst_wake_pkg::st_hold : rst_wake_pkg::st_pin_low;
      next_count = 17'h0;
      next_wdog = 17'h0;
      next_cpu_reset = 1'b1; // RULE15
      next_cpu_clk = 1'b0;
      next_timer_run = 1'b0;
      next_can_rx = 1'b0;
      next_pin_oe = supply_low_in | ~ext_reset; // RULE17 RULE19
      next_ctrl = `CTRL_RESET;
      if (supply_low_in) next_cause[`CAUSE_LOWV] = 1'b1; // RULE19
      if (ext_reset) next_cause[`CAUSE_PIN] = 1'b1; // RULE16
      if (wdog == WDOG_M1 && ctrl[`CTRL_WDOG_EN]) next_cause[`CAUSE_WDOG] = 1'b1;
      if (bad_opcode_in || (stop_instr_in && !ctrl[`CTRL_STOPEN])) begin
        next_cause[`CAUSE_BADOP] = 1'b1; // RULE21
      end
      if (opcode_fetch_in && unmapped_in) next_cause[`CAUSE_BADADR] = 1'b1; // RULE22
    end
  end

  // ==========================================================
  // State registers; power-on reset sets POR and low-voltage flags
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= rst_wake_pkg::st_power;
      count <= 17'h0;
      cause <= `CAUSE_POR_VALUE | 8'h02; // RULE18
      ctrl <= `CTRL_RESET;
      wdog <= 17'h0;
      sample_cnt <= 6'h0;
      irq_prev <= 1'b1;
      prdata_out <= 32'h0;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      reset_pin_oe_out <= 1'b1;
      cpu_reset_out <= 1'b1;
      cpu_clk_en_out <= 1'b0;
      sys_clk_en_out <= 1'b0;
      timer_run_out <= 1'b0;
      can_rx_en_out <= 1'b0;
      vector_load_out <= 1'b0;
      vector_out <= `VEC_RESET;
    end else begin
      state <= next_state;
      count <= next_count;
      cause <= next_cause;
      ctrl <= next_ctrl;
      wdog <= next_wdog;
      sample_cnt <= next_sample_cnt;
      irq_prev <= next_irq_prev;
      prdata_out <= next_prdata;
      pready_out <= next_pready;
      pslverr_out <= next_pslverr;
      reset_pin_oe_out <= next_pin_oe;
      cpu_reset_out <= next_cpu_reset;
      cpu_clk_en_out <= next_cpu_clk;
      sys_clk_en_out <= next_sys_clk;
      timer_run_out <= next_timer_run;
      can_rx_en_out <= next_can_rx;
      vector_load_out <= next_vec_load;
      vector_out <= next_vector;
    end
  end

  // Pin only ever pulled low, so its output value is a constant flop
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reset_pin_out <= 1'b0;
    end else begin
      reset_pin_out <= 1'b0;
    end
  end

  // Bus clock after reset is oscillator over four
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_div4_out <= 1'b1;
    end else begin
      bus_div4_out <= cpu_reset_out | bus_div4_out; // RULE15
    end
  end
endmodule : reset_wake_sequencer

// File: sim/reset_wake_sequencer_checker.sv
`timescale 1ns/1ps
// ====
// Port-level checker
module reset_wake_sequencer_checker (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic irq_pin_in,
  input wire logic bad_opcode_in,
  input wire logic supply_low_in,
  input wire logic reset_pin_oe_out,
  input wire logic cpu_reset_out,
  input wire logic cpu_clk_en_out,
  input wire logic sys_clk_en_out,
  input wire logic timer_run_out,
  input wire logic can_rx_en_out,
  input wire logic vector_load_out,
  input wire logic [15:0] vector_out
);
  logic [15:0] drive_cnt, next_drive_cnt;
  logic [7:0] hold_cnt, next_hold_cnt;
  logic int_seen, next_int_seen;
  // Run lengths; pin-driven resets only, pin-held resets stretch the hold
  always_comb begin
    next_drive_cnt = reset_pin_oe_out ? drive_cnt + 16'h1 : 16'h0;
    next_hold_cnt = (reset_pin_oe_out || !cpu_reset_out) ? 8'h0 : hold_cnt + 8'h1;
    next_int_seen = reset_pin_oe_out || (int_seen && cpu_reset_out);
  end
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      drive_cnt <= 16'h0;
      hold_cnt <= 8'h0;
      int_seen <= 1'b0;
    end else begin
      drive_cnt <= next_drive_cnt;
      hold_cnt <= next_hold_cnt;
      int_seen <= next_int_seen;
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_reset_fetch; vector_load_out && vector_out == 16'hfffe; endsequence
  sequence s_irq_fetch; vector_load_out && vector_out == 16'hfffa; endsequence
  property p_drive_len; $fell(reset_pin_oe_out) |-> drive_cnt >= 16'd32; endproperty
  a_drive_len: assert property (p_drive_len) else $error("pin drive short");
  property p_hold_len; $fell(cpu_reset_out) && int_seen |-> hold_cnt == 8'd32; endproperty
  a_hold_len: assert property (p_hold_len) else $error("cpu hold length");
  property p_reset_fetch; $fell(cpu_reset_out) |-> ##[0:2] s_reset_fetch; endproperty
  a_reset_fetch: assert property (p_reset_fetch) else $error("no reset fetch");
  property p_irq_wake;
    $fell(irq_pin_in) && sys_clk_en_out && !cpu_clk_en_out && !cpu_reset_out
      |-> ##[1:4] s_irq_fetch;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("irq wake missing");
  property p_timer_halt; !sys_clk_en_out |-> !timer_run_out; endproperty
  a_timer_halt: assert property (p_timer_halt) else $error("timer runs in stop");
  property p_can_quiet; !sys_clk_en_out |-> !can_rx_en_out; endproperty
  a_can_quiet: assert property (p_can_quiet) else $error("can rx early");
  property p_bad_opcode; bad_opcode_in && !cpu_reset_out |-> ##[1:3] reset_pin_oe_out; endproperty
  a_bad_opcode: assert property (p_bad_opcode) else $error("no opcode reset");
  property p_supply_hold; supply_low_in [*3] |-> reset_pin_oe_out; endproperty
  a_supply_hold: assert property (p_supply_hold) else $error("pin free on low supply");
endmodule : reset_wake_sequencer_checker
bind reset_wake_sequencer reset_wake_sequencer_checker checker_inst (
  .core_clk_in, .sys_rst_in, .irq_pin_in, .bad_opcode_in, .supply_low_in,
  .reset_pin_oe_out, .cpu_reset_out, .cpu_clk_en_out, .sys_clk_en_out,
  .timer_run_out, .can_rx_en_out, .vector_load_out, .vector_out
);

// File: sim/reset_pin_partner.sv
`timescale 1ns/1ps
// ====
// Reset pin with pull-up
module reset_pin_partner (
  input wire logic drive_in,
  input wire logic level_in,
  input wire logic hold_low_in,
  output logic pin_out
);
  // Wired-AND of both drivers; released pin floats high on its pull-up
  assign pin_out = (drive_in ? level_in : 1'b1) & !hold_low_in;
endmodule : reset_pin_partner

// File: sim/tb_reset_wake_sequencer.sv
`timescale 1ns/1ps
// ====
// Bench top
module tb_reset_wake_sequencer;
  localparam int STAB = 64;
  localparam logic [15:0] VT [18] = '{16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2, 16'hfff0,
    16'hffee, 16'hffec, 16'hffea, 16'hffe8, 16'hffe6, 16'hffe4, 16'hffe2, 16'hffe0,
    16'hffde, 16'hffdc, 16'hffda, 16'hffd8, 16'hffd6};
  logic clk, rst, psel, penable, pwrite, pready, pslverr, e, supply_low, bad_op, stop_i;
  logic wait_i, op_fetch, unmapped, irq, key_fall, brk, pin, pin_val, pin_oe, ext_low;
  logic cpu_rst, cpu_en, sys_en, tmr_run, can_en, div4, vld;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, rnd;
  logic [17:0] wake_req, m;
  logic [15:0] vec;
  int n_errors, tests_run, g;
  int cyc = 0;
  reset_wake_sequencer #(.STAB_CYCLES(STAB), .WDOG_CYCLES(256)) reset_wake_sequencer_inst (
    .core_clk_in(clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .reset_pin_in(pin), .reset_pin_out(pin_val),
    .reset_pin_oe_out(pin_oe), .supply_low_in(supply_low), .bad_opcode_in(bad_op),
    .stop_instr_in(stop_i), .wait_instr_in(wait_i), .opcode_fetch_in(op_fetch),
    .unmapped_in(unmapped), .irq_pin_in(irq), .keypad_fall_in(key_fall), .break_in(brk),
    .wake_req_in(wake_req), .cpu_reset_out(cpu_rst), .cpu_clk_en_out(cpu_en),
    .sys_clk_en_out(sys_en), .timer_run_out(tmr_run), .can_rx_en_out(can_en),
    .bus_div4_out(div4), .vector_load_out(vld), .vector_out(vec));
  reset_pin_partner reset_pin_partner_inst (.drive_in(pin_oe), .level_in(pin_val),
    .hold_low_in(ext_low), .pin_out(pin));
  always #2.5 clk = ~clk;
  // Hang guard, well above the few thousand cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic int low_idx(input logic [17:0] v);
    for (int i = 17; i >= 0; i--) if (v[i]) low_idx = i;
  endfunction : low_idx
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // APB master: holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Answer and read data taken at the rising edge that sees pready high
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // Gap from pin release to CPU release
  task automatic rec(output int gap);
    do @(negedge clk); while (pin_oe !== 1'b1);
    do @(negedge clk); while (pin_oe !== 1'b0);
    gap = 0;
    while (cpu_rst !== 1'b0) begin @(negedge clk); gap++; end
    @(posedge clk);
  endtask : rec
  task automatic wake(input logic ent, stp, input int src, input logic [17:0] mk,
                      input logic [15:0] ev, input int lo);
    int n;
    if (ent) begin
      if (stp) stop_i <= 1'b1;
      else wait_i <= 1'b1;
      @(posedge clk);
      stop_i <= 1'b0;
      wait_i <= 1'b0;
      repeat (3) @(posedge clk);
    end
    chk(cpu_en, 0);
    chk(tmr_run, !stp);
    case (src)
      0: wake_req <= mk;
      1: irq <= 1'b0;
      2: key_fall <= 1'b1;
      default: brk <= 1'b1;
    endcase
    @(posedge clk);
    key_fall <= 1'b0;
    brk <= 1'b0;
    n = 0;
    do begin @(negedge clk); n++; end while (vld !== 1'b1 && n < 9000);
    chk(vec, ev);
    chk({cpu_en, tmr_run, sys_en}, 3'h7);
    if (lo > 0) chk(n >= lo && n <= lo + 8, 1);
    @(posedge clk);
    wake_req <= 18'h0;
    irq <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : wake
  // Main sequence
  initial begin
    {clk, psel, penable, pwrite, supply_low, bad_op, stop_i, wait_i, op_fetch} = 9'h0;
    {unmapped, key_fall, brk, ext_low, paddr, pwdata, wake_req} = '0;
    {rst, irq} = 2'h3;
    rnd = 32'h00000038;
    n_errors = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rec(g);
    chk(g, 32);
    apb(0, 12'h000, 0);
    chk(r, 32'h82);
    apb(1, 12'h000, 32'hff);
    apb(0, 12'h000, 0);
    chk(r, 0);
    apb(0, 12'h010, 0);
    chk(e, 1);
    apb(0, 12'h008, 0);
    chk(r, 32'hfffe);
    $display("test power-on done");
    apb(1, 12'h004, 32'h2);
    apb(0, 12'h004, 0);
    chk(r, 32'h2);
    for (int i = 0; i < 18; i++) wake(1, 0, 0, 18'h1 << i, VT[i], 0);
    repeat (8) begin
      rnd = lfsr(rnd);
      m = rnd[17:0] | 18'h20000;
      wake(1, 0, 0, m, VT[low_idx(m)], 0);
    end
    wake(1, 1, 1, 0, 16'hfffa, STAB);
    wake(1, 1, 2, 0, 16'hffe0, STAB);
    wake(1, 1, 0, 18'h4000, 16'hffdc, STAB);
    wake(1, 1, 0, 18'h8000, 16'hffda, STAB);
    stop_i <= 1'b1;
    @(posedge clk);
    stop_i <= 1'b0;
    wake_req <= 18'h8;
    repeat (100) @(posedge clk);
    chk(sys_en, 0);
    wake_req <= 18'h0;
    wake(0, 1, 1, 0, 16'hfffa, STAB);
    apb(1, 12'h004, 32'h3);
    wake(1, 1, 1, 0, 16'hfffa, 32);
    wait_i <= 1'b1;
    @(posedge clk);
    wait_i <= 1'b0;
    brk <= 1'b1;
    @(posedge clk);
    brk <= 1'b0;
    repeat (20) @(posedge clk);
    chk(cpu_en, 0);
    wake(0, 0, 1, 0, 16'hfffa, 0);
    apb(1, 12'h004, 32'h4);
    wake(1, 0, 3, 0, 16'hfffc, 0);
    $display("test wake done");
    unmapped <= 1'b1;
    @(posedge clk);
    unmapped <= 1'b0;
    repeat (10) @(posedge clk);
    chk(cpu_rst, 0);
    for (int k = 0; k < 4; k++) begin
      if (k == 3) begin
        apb(1, 12'h004, 32'h9);
        repeat (3) begin
          repeat (150) @(posedge clk);
          rnd = lfsr(rnd);
          apb(1, 12'h00c, rnd);
        end
        chk(cpu_rst, 0);
      end
      // Earlier reset set short recovery and left stop enable clear; write zero so stop is illegal
      if (k == 1) apb(1, 12'h004, 32'h0);
      bad_op <= (k == 0);
      stop_i <= (k == 1);
      {op_fetch, unmapped} <= {2{k == 2}};
      @(posedge clk);
      {bad_op, stop_i, op_fetch, unmapped} <= 4'h0;
      rec(g);
      chk(g, 32);
      apb(0, 12'h000, 0);
      chk(r, k == 3 ? 32'h20 : (k == 2 ? 32'h08 : 32'h10));
    end
    supply_low <= 1'b1;
    repeat (20) @(posedge clk);
    chk({pin_oe, pin_val}, 2'h2);
    supply_low <= 1'b0;
    rec(g);
    chk(g, 32);
    apb(0, 12'h000, 0);
    chk(r, 32'h02);
    ext_low <= 1'b1;
    repeat (10) @(posedge clk);
    chk({cpu_rst, div4}, 2'h3);
    ext_low <= 1'b0;
    while (cpu_rst !== 1'b0) @(posedge clk);
    apb(0, 12'h000, 0);
    chk(r, 32'h40);
    $display("test resets done");
    test_done();
  end
endmodule : tb_reset_wake_sequencer
